// File: logic/lsp_pkg.sv
// Purpose: Shared constants for the shared LCD port pin block.
// Assumes: 32-bit APB register bus, one register per aligned word.
// Notes: Direction bits use 1 for input, mode bits use 1 for control mode.
package lsp_pkg;
	localparam int unsigned PORT_A_WIDTH = 7;
	localparam int unsigned PORT_B_WIDTH = 8;
	localparam int unsigned PORT_C_WIDTH = 4;
	localparam int unsigned PULLUP_WIDTH = 12;
	localparam int unsigned DED_SEG_WIDTH = 16;
	localparam int unsigned SEG_WIDTH = 28;
	localparam int unsigned COM_WIDTH = 4;
	localparam int unsigned ADDR_WIDTH = 8;

	// Segment numbers carried by the lowest pin of each shared port.
	localparam int unsigned PORT_B_SEG_TOP = 27;
	localparam int unsigned PORT_C_SEG_TOP = 19;

	// Register byte offsets.
	localparam logic [7:0] OFF_PORT_A_MODE = 8'h00;
	localparam logic [7:0] OFF_PORT_A_DATA = 8'h04;
	localparam logic [7:0] OFF_PORT_B_DIR = 8'h08;
	localparam logic [7:0] OFF_PORT_B_MODE = 8'h0C;
	localparam logic [7:0] OFF_PORT_B_DATA = 8'h10;
	localparam logic [7:0] OFF_PORT_C_DIR = 8'h14;
	localparam logic [7:0] OFF_PORT_C_MODE = 8'h18;
	localparam logic [7:0] OFF_PORT_C_DATA = 8'h1C;
	localparam logic [7:0] OFF_PULLUP = 8'h20;
	localparam logic [7:0] OFF_STATUS = 8'h24;

	// Pull-up option layout: port B in the low byte, port C above it.
	localparam int unsigned PULLUP_C_LSB = 8;

	// Status register bit positions.
	localparam int unsigned STAT_PIN_RESET = 0;

	// Reset values.
	localparam logic [6:0] RST_PORT_A_MODE = 7'h00;
	localparam logic [7:0] RST_PORT_B_DIR = 8'hFF;
	localparam logic [7:0] RST_PORT_B_MODE = 8'h00;
	localparam logic [7:0] RST_PORT_B_LATCH = 8'h00;
	localparam logic [3:0] RST_PORT_C_DIR = 4'hF;
	localparam logic [3:0] RST_PORT_C_MODE = 4'h0;
	localparam logic [3:0] RST_PORT_C_LATCH = 4'h0;
	localparam logic [11:0] RST_PULLUP = 12'h000;
endpackage

// File: logic/lsp_pin_cell.sv
// Purpose: Next-state logic of one shared port pin.
// Assumes: Pin level is already synchronised; outputs are registered by the
//	caller.
// Notes: Purely combinational.
`timescale 1ns/1ps
module lsp_pin_cell (
	input  wire logic pin_level,
	input  wire logic ctrl_mode,
	input  wire logic dir_input,
	input  wire logic latch,
	input  wire logic pullup_opt,
	input  wire logic seg_data,
	output logic      pin_out,
	output logic      pin_oe,
	output logic      pullup_en,
	output logic      read_bit
);
	always_comb begin
		if (ctrl_mode) begin
			// Control mode hands the pin to the segment driver.
			pin_out = seg_data;
			pin_oe = 1'b1;
			pullup_en = 1'b0;
			read_bit = 1'b0;
		end else if (dir_input) begin
			pin_out = 1'b0;
			pin_oe = 1'b0;
			pullup_en = pullup_opt;
			read_bit = pin_level;
		end else begin
			pin_out = latch;
			pin_oe = 1'b1;
			pullup_en = 1'b0;
			read_bit = latch;
		end
	end
endmodule // lsp_pin_cell

// File: logic/lsp_port_pins.sv
// Purpose: Port pin logic for the input port, two LCD-shared ports and the
//	dedicated segment and common outputs, with an APB register file.
// Assumes: seg_data and com_data come from the LCD controller on clock.
// Notes: Pins are synchronised by two flip-flops before use.
// Contract
// - Seven-pin port is input only, never drives
// - Control mode routes port A to converter, comparator
// - Port B direction chosen per pin
// - Port B input pins get optional pull-up
// - Port B control mode drives segments 27 down to 20
// - Port C direction chosen per pin
// - Port C input pins share the pull-up register
// - Port C control mode drives segments 19 down to 16
// - Sixteen dedicated segment outputs always drive segments
// - Four dedicated common outputs from the controller
// - Reset pin is active low, initialises device
`timescale 1ns/1ps
module lsp_port_pins (
	input  wire logic        clock,
	input  wire logic        rst,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// External reset pin, active low.
	input  wire logic        reset_pin_n,
	output logic             pin_reset_active,
	// LCD controller drive.
	input  wire logic [27:0] seg_data,
	input  wire logic [3:0]  com_data,
	// Input-only port and its analog routing.
	input  wire logic [6:0]  input_port_a_pins,
	output logic [6:0]       converter_analog_inputs,
	output logic             comparator_input,
	output logic             comparator_reference,
	// Shared port B.
	input  wire logic [7:0]  port_b_pins_in,
	output logic [7:0]       port_b_pins_out,
	output logic [7:0]       port_b_pins_oe,
	output logic [7:0]       port_b_pullup_en,
	// Shared port C.
	input  wire logic [3:0]  port_c_pins_in,
	output logic [3:0]       port_c_pins_out,
	output logic [3:0]       port_c_pins_oe,
	output logic [3:0]       port_c_pullup_en,
	// Dedicated LCD outputs.
	output logic [15:0]      dedicated_segment_outputs,
	output logic [3:0]       lcd_common_outputs
);
	typedef struct packed {
		logic        rst_meta;
		logic        rst_sync;
		logic [6:0]  a_meta;
		logic [6:0]  a_sync;
		logic [7:0]  b_meta;
		logic [7:0]  b_sync;
		logic [3:0]  c_meta;
		logic [3:0]  c_sync;
		logic [6:0]  a_mode;
		logic [7:0]  port_b_direction;
		logic [7:0]  b_mode;
		logic [7:0]  b_latch;
		logic [3:0]  port_c_direction;
		logic [3:0]  c_mode;
		logic [3:0]  c_latch;
		logic [11:0] port_bc_pullup_option;
		logic [31:0] rdata;
		logic        err;
		logic [7:0]  b_out;
		logic [7:0]  b_oe;
		logic [7:0]  b_pu;
		logic [3:0]  c_out;
		logic [3:0]  c_oe;
		logic [3:0]  c_pu;
		logic [15:0] ded_seg;
		logic [3:0]  com;
		logic [6:0]  adc;
		logic        cmp_in;
		logic        cmp_ref;
	} lsp_state_t;

	lsp_state_t s_q;
	lsp_state_t s_d;

	logic [7:0] b_out_w;
	logic [7:0] b_oe_w;
	logic [7:0] b_pu_w;
	logic [7:0] b_rd_w;
	logic [3:0] c_out_w;
	logic [3:0] c_oe_w;
	logic [3:0] c_pu_w;
	logic [3:0] c_rd_w;
	logic       setup;
	logic       access;
	logic       mapped;

	// Shared pins: lowest pin carries the highest segment number.
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_port_b
			lsp_pin_cell u_cell (
				.pin_level  (s_q.b_sync[gi]),
				.ctrl_mode  (s_q.b_mode[gi]),
				.dir_input  (s_q.port_b_direction[gi]),
				.latch      (s_q.b_latch[gi]),
				.pullup_opt (s_q.port_bc_pullup_option[gi]),
				.seg_data   (seg_data[lsp_pkg::PORT_B_SEG_TOP - gi]),
				.pin_out    (b_out_w[gi]),
				.pin_oe     (b_oe_w[gi]),
				.pullup_en  (b_pu_w[gi]),
				.read_bit   (b_rd_w[gi])
			);
		end
		for (gi = 0; gi < 4; gi++) begin : g_port_c
			lsp_pin_cell u_cell (
				.pin_level  (s_q.c_sync[gi]),
				.ctrl_mode  (s_q.c_mode[gi]),
				.dir_input  (s_q.port_c_direction[gi]),
				.latch      (s_q.c_latch[gi]),
				.pullup_opt (s_q.port_bc_pullup_option[
					lsp_pkg::PULLUP_C_LSB + gi]),
				.seg_data   (seg_data[lsp_pkg::PORT_C_SEG_TOP - gi]),
				.pin_out    (c_out_w[gi]),
				.pin_oe     (c_oe_w[gi]),
				.pullup_en  (c_pu_w[gi]),
				.read_bit   (c_rd_w[gi])
			);
		end
	endgenerate

	assign setup = psel && !penable;
	assign access = psel && penable;

	always_comb begin
		unique case (paddr)
			lsp_pkg::OFF_PORT_A_MODE,
			lsp_pkg::OFF_PORT_A_DATA,
			lsp_pkg::OFF_PORT_B_DIR,
			lsp_pkg::OFF_PORT_B_MODE,
			lsp_pkg::OFF_PORT_B_DATA,
			lsp_pkg::OFF_PORT_C_DIR,
			lsp_pkg::OFF_PORT_C_MODE,
			lsp_pkg::OFF_PORT_C_DATA,
			lsp_pkg::OFF_PULLUP,
			lsp_pkg::OFF_STATUS: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	always_comb begin
		s_d = s_q;
		s_d.rst_meta = reset_pin_n;
		s_d.rst_sync = s_q.rst_meta;
		s_d.a_meta = input_port_a_pins;
		s_d.a_sync = s_q.a_meta;
		s_d.b_meta = port_b_pins_in;
		s_d.b_sync = s_q.b_meta;
		s_d.c_meta = port_c_pins_in;
		s_d.c_sync = s_q.c_meta;

		// Registered pin drive.
		s_d.b_out = b_out_w;
		s_d.b_oe = b_oe_w;
		s_d.b_pu = b_pu_w;
		s_d.c_out = c_out_w;
		s_d.c_oe = c_oe_w;
		s_d.c_pu = c_pu_w;
		s_d.ded_seg = seg_data[15:0];
		s_d.com = com_data;
		s_d.adc = s_q.a_sync & s_q.a_mode;
		s_d.cmp_in = s_q.a_sync[0] & s_q.a_mode[0];
		s_d.cmp_ref = s_q.a_sync[1] & s_q.a_mode[1];

		// Read data is captured in the setup cycle.
		if (setup) begin
			s_d.rdata = 32'h0000_0000;
			s_d.err = !mapped;
			unique case (paddr)
				lsp_pkg::OFF_PORT_A_MODE: s_d.rdata[6:0] = s_q.a_mode;
				lsp_pkg::OFF_PORT_A_DATA:
					s_d.rdata[6:0] = s_q.a_sync & ~s_q.a_mode;
				lsp_pkg::OFF_PORT_B_DIR: s_d.rdata[7:0] = s_q.port_b_direction;
				lsp_pkg::OFF_PORT_B_MODE: s_d.rdata[7:0] = s_q.b_mode;
				lsp_pkg::OFF_PORT_B_DATA: s_d.rdata[7:0] = b_rd_w;
				lsp_pkg::OFF_PORT_C_DIR: s_d.rdata[3:0] = s_q.port_c_direction;
				lsp_pkg::OFF_PORT_C_MODE: s_d.rdata[3:0] = s_q.c_mode;
				lsp_pkg::OFF_PORT_C_DATA: s_d.rdata[3:0] = c_rd_w;
				lsp_pkg::OFF_PULLUP:
					s_d.rdata[11:0] = s_q.port_bc_pullup_option;
				lsp_pkg::OFF_STATUS:
					s_d.rdata[lsp_pkg::STAT_PIN_RESET] = !s_q.rst_sync;
				default: s_d.rdata = 32'h0000_0000;
			endcase
		end

		// Writes take effect at the access edge.
		if (access && pwrite) begin
			unique case (paddr)
				lsp_pkg::OFF_PORT_A_MODE: s_d.a_mode = pwdata[6:0];
				lsp_pkg::OFF_PORT_B_DIR: s_d.port_b_direction = pwdata[7:0];
				lsp_pkg::OFF_PORT_B_MODE: s_d.b_mode = pwdata[7:0];
				lsp_pkg::OFF_PORT_B_DATA: s_d.b_latch = pwdata[7:0];
				lsp_pkg::OFF_PORT_C_DIR: s_d.port_c_direction = pwdata[3:0];
				lsp_pkg::OFF_PORT_C_MODE: s_d.c_mode = pwdata[3:0];
				lsp_pkg::OFF_PORT_C_DATA: s_d.c_latch = pwdata[3:0];
				lsp_pkg::OFF_PULLUP:
					s_d.port_bc_pullup_option = pwdata[11:0];
				default: s_d.err = s_q.err;
			endcase
		end

		// A low reset pin holds the port configuration at its reset values.
		if (!s_q.rst_sync) begin
			s_d.a_mode = lsp_pkg::RST_PORT_A_MODE;
			s_d.port_b_direction = lsp_pkg::RST_PORT_B_DIR;
			s_d.b_mode = lsp_pkg::RST_PORT_B_MODE;
			s_d.b_latch = lsp_pkg::RST_PORT_B_LATCH;
			s_d.port_c_direction = lsp_pkg::RST_PORT_C_DIR;
			s_d.c_mode = lsp_pkg::RST_PORT_C_MODE;
			s_d.c_latch = lsp_pkg::RST_PORT_C_LATCH;
			s_d.port_bc_pullup_option = lsp_pkg::RST_PULLUP;
			s_d.b_oe = 8'h00;
			s_d.c_oe = 4'h0;
			s_d.b_pu = 8'h00;
			s_d.c_pu = 4'h0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			s_q <= '0;
			s_q.rst_meta <= 1'b1;
			s_q.rst_sync <= 1'b1;
			s_q.port_b_direction <= lsp_pkg::RST_PORT_B_DIR;
			s_q.port_c_direction <= lsp_pkg::RST_PORT_C_DIR;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.rdata;
	assign pready = 1'b1;
	assign pslverr = access && s_q.err;
	assign pin_reset_active = !s_q.rst_sync;
	assign converter_analog_inputs = s_q.adc;
	assign comparator_input = s_q.cmp_in;
	assign comparator_reference = s_q.cmp_ref;
	assign port_b_pins_out = s_q.b_out;
	assign port_b_pins_oe = s_q.b_oe;
	assign port_b_pullup_en = s_q.b_pu;
	assign port_c_pins_out = s_q.c_out;
	assign port_c_pins_oe = s_q.c_oe;
	assign port_c_pullup_en = s_q.c_pu;
	assign dedicated_segment_outputs = s_q.ded_seg;
	assign lcd_common_outputs = s_q.com;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	chk_b_low_seg: assert property (
		s_q.b_mode[0] && s_q.rst_sync |=>
			port_b_pins_oe[0] && port_b_pins_out[0] == $past(seg_data[27]))
		else $error("port B pin 0 does not carry segment 27");
	chk_b_high_seg: assert property (
		s_q.b_mode[7] && s_q.rst_sync |=>
			port_b_pins_out[7] == $past(seg_data[20]))
		else $error("port B pin 7 does not carry segment 20");
	chk_c_low_seg: assert property (
		s_q.c_mode[0] && s_q.rst_sync |=>
			port_c_pins_oe[0] && port_c_pins_out[0] == $past(seg_data[19]))
		else $error("port C pin 0 does not carry segment 19");
	chk_b_out_latch: assert property (
		!s_q.b_mode[7] && !s_q.port_b_direction[7] && s_q.rst_sync |=>
			port_b_pins_oe[7] && port_b_pins_out[7] == $past(s_q.b_latch[7]))
		else $error("port B output pin does not drive its latch");
	chk_b_in_float: assert property (
		!s_q.b_mode[3] && s_q.port_b_direction[3] |=> !port_b_pins_oe[3])
		else $error("port B input pin is driven");
	chk_b_pullup: assert property (
		!s_q.b_mode[1] && s_q.port_b_direction[1] && s_q.rst_sync
			&& s_q.port_bc_pullup_option[1] |=> port_b_pullup_en[1])
		else $error("port B pull-up not enabled");
	chk_c_pullup: assert property (
		!s_q.c_mode[3] && s_q.port_c_direction[3] && s_q.rst_sync
			&& s_q.port_bc_pullup_option[11] |=> port_c_pullup_en[3])
		else $error("port C pull-up not enabled");
	chk_ded_seg: assert property (
		1'b1 |=> dedicated_segment_outputs == $past(seg_data[15:0]))
		else $error("dedicated segments do not follow the controller");
	chk_com_out: assert property (
		1'b1 |=> lcd_common_outputs == $past(com_data))
		else $error("common outputs do not follow the controller");
	chk_cmp_route: assert property (
		s_q.a_mode[0] |=> comparator_input == $past(s_q.a_sync[0]))
		else $error("comparator input not routed from port A");
	chk_pin_reset: assert property (
		!s_q.rst_sync |=> s_q.b_mode == 8'h00 && port_b_pins_oe == 8'h00
			&& port_c_pins_oe == 4'h0)
		else $error("reset pin low did not initialise the ports");
	chk_a_read: assert property (
		setup && paddr == lsp_pkg::OFF_PORT_A_DATA |=>
			prdata[31:7] == 25'h0000000 && (prdata[6:0] & s_q.a_mode) == 7'h00)
		else $error("port A read shows control-mode or upper bits");

	// Port C gets the same drive and release checks as port B.
	chk_c_high_seg: assert property (
		s_q.c_mode[3] && s_q.rst_sync |=>
			port_c_pins_out[3] == $past(seg_data[16]))
		else $error("port C pin 3 does not carry segment 16");
	chk_c_out_latch: assert property (
		!s_q.c_mode[3] && !s_q.port_c_direction[3] && s_q.rst_sync |=>
			port_c_pins_oe[3] && port_c_pins_out[3] == $past(s_q.c_latch[3]))
		else $error("port C output pin does not drive its latch");
	chk_c_in_float: assert property (
		!s_q.c_mode[0] && s_q.port_c_direction[0] |=> !port_c_pins_oe[0])
		else $error("port C input pin is driven");
	chk_b_ctrl_pullup: assert property (
		s_q.b_mode[1] |=> !port_b_pullup_en[1])
		else $error("port B control-mode pin has its pull-up on");
	chk_c_ctrl_pullup: assert property (
		s_q.c_mode[2] |=> !port_c_pullup_en[2])
		else $error("port C control-mode pin has its pull-up on");
	chk_cmp_ref_route: assert property (
		s_q.a_mode[1] |=> comparator_reference == $past(s_q.a_sync[1]))
		else $error("comparator reference not routed from port A");
	chk_adc_all: assert property (
		s_q.a_mode == 7'h7F |=>
			converter_analog_inputs == $past(s_q.a_sync))
		else $error("converter inputs do not follow port A pins");
	chk_adc_idle: assert property (
		s_q.a_mode == 7'h00 |=> converter_analog_inputs == 7'h00)
		else $error("converter inputs active in port mode");

	// A data read shows the pin for inputs and the latch for outputs.
	chk_b_pin_read: assert property (
		setup && paddr == lsp_pkg::OFF_PORT_B_DATA && !s_q.b_mode[0]
			&& s_q.port_b_direction[0] |=> prdata[0] == $past(s_q.b_sync[0]))
		else $error("port B input read does not show the pin level");
	chk_b_latch_read: assert property (
		setup && paddr == lsp_pkg::OFF_PORT_B_DATA && !s_q.b_mode[7]
			&& !s_q.port_b_direction[7] |=> prdata[7] == $past(s_q.b_latch[7]))
		else $error("port B output read does not show the latch");
endmodule // lsp_port_pins

// File: test/lsp_far_side.sv
// Purpose: Far-side model of one bidirectional port's external wires.
// Assumes: An external driver and the device never drive one wire together.
// Notes: A released wire without pull-up toggles, so it never reads stable.
`timescale 1ns/1ps
module lsp_far_side #(
	parameter int unsigned N = 8
) (
	input  wire logic         clock,
	input  wire logic [N-1:0] ext_val,
	input  wire logic [N-1:0] ext_en,
	input  wire logic [N-1:0] dev_out,
	input  wire logic [N-1:0] dev_oe,
	input  wire logic [N-1:0] dev_pullup,
	output logic      [N-1:0] pin_level
);
	logic [N-1:0] float_q = '0;
	always_ff @(posedge clock) begin
		float_q <= ~float_q;
	end
	always_comb begin
		for (int i = 0; i < N; i++) begin
			if (dev_oe[i])
				pin_level[i] = dev_out[i];
			else if (ext_en[i])
				pin_level[i] = ext_val[i];
			else if (dev_pullup[i])
				pin_level[i] = 1'b1;
			else
				pin_level[i] = float_q[i];
		end
	end
endmodule // lsp_far_side

// File: test/testbench.sv
// Purpose: Self-checking bench for the shared LCD port pin block.
// Assumes: APB answers with pready; pins settle within a few edges.
// Notes: Each scenario is a task that drives and judges on its own.
`timescale 1ns/1ps
module testbench;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        reset_pin_n = 1'b1;
	logic        pin_reset_active;
	logic [27:0] seg_data = 28'h0;
	logic [3:0]  com_data = 4'h0;
	logic [6:0]  pa_in = 7'h00;
	logic [6:0]  an_out;
	logic        cmp_in;
	logic        cmp_ref;
	logic [7:0]  b_in, b_out, b_oe, b_pu, b_ext = 8'h00, b_ext_en = 8'h00;
	logic [3:0]  c_in, c_out, c_oe, c_pu, c_ext = 4'h0, c_ext_en = 4'h0;
	logic [15:0] ded_seg;
	logic [3:0]  com_out;
	int          err_count = 0;
	int          n_tests = 0;

	initial begin
		forever #20 clock = ~clock;
	end

	lsp_port_pins u_dut (.clock(clock), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.reset_pin_n(reset_pin_n), .pin_reset_active(pin_reset_active),
		.seg_data(seg_data), .com_data(com_data), .input_port_a_pins(pa_in),
		.converter_analog_inputs(an_out), .comparator_input(cmp_in),
		.comparator_reference(cmp_ref), .port_b_pins_in(b_in),
		.port_b_pins_out(b_out), .port_b_pins_oe(b_oe),
		.port_b_pullup_en(b_pu), .port_c_pins_in(c_in),
		.port_c_pins_out(c_out), .port_c_pins_oe(c_oe),
		.port_c_pullup_en(c_pu), .dedicated_segment_outputs(ded_seg),
		.lcd_common_outputs(com_out));
	lsp_far_side #(.N(8)) u_far_b (.clock(clock), .ext_val(b_ext),
		.ext_en(b_ext_en), .dev_out(b_out), .dev_oe(b_oe),
		.dev_pullup(b_pu), .pin_level(b_in));
	lsp_far_side #(.N(4)) u_far_c (.clock(clock), .ext_val(c_ext),
		.ext_en(c_ext_en), .dev_out(c_out), .dev_oe(c_oe),
		.dev_pullup(c_pu), .pin_level(c_in));

	task automatic print_verdict();
		$display("checks %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen,
			input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] addr,
			input logic [31:0] wdata, output logic [31:0] rdata,
			output logic err);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wdata;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			err_count++;
			print_verdict();
		end else begin
			rdata = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task automatic wr(input logic [7:0] addr, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, addr, d, r, e);
	endtask

	task automatic rd(input logic [7:0] addr, input logic [31:0] exp,
			input string name);
		logic [31:0] r;
		logic        e;
		apb(1'b0, addr, 32'h0, r, e);
		check(name, r, exp);
		check({name, " err"}, {31'h0, e}, 32'h0);
	endtask

	task automatic settle();
		repeat (5) @(posedge clock);
	endtask

	task automatic t_reset_values();
		rd(lsp_pkg::OFF_PORT_B_DIR, 32'hFF, "b dir");
		rd(lsp_pkg::OFF_PORT_C_DIR, 32'hF, "c dir");
		rd(lsp_pkg::OFF_PULLUP, 32'h0, "pullup");
		check("oe", {b_oe, c_oe}, 32'h0);
	endtask

	task automatic t_port_a();
		pa_in <= 7'h37;
		wr(lsp_pkg::OFF_PORT_A_MODE, 32'h00);
		settle();
		rd(lsp_pkg::OFF_PORT_A_DATA, 32'h37, "a data");
		check("an idle", an_out, 32'h0);
		wr(lsp_pkg::OFF_PORT_A_MODE, 32'h7F);
		settle();
		check("an", {cmp_ref, cmp_in, an_out}, 32'h1B7);
		rd(lsp_pkg::OFF_PORT_A_DATA, 32'h0, "a ctrl data");
	endtask

	task automatic t_outputs();
		wr(lsp_pkg::OFF_PORT_B_DATA, 32'hC3);
		wr(lsp_pkg::OFF_PORT_C_DATA, 32'h9);
		wr(lsp_pkg::OFF_PULLUP, 32'hFFF);
		wr(lsp_pkg::OFF_PORT_B_DIR, 32'h0F);
		wr(lsp_pkg::OFF_PORT_C_DIR, 32'h3);
		b_ext <= 8'h00;
		b_ext_en <= 8'h05;
		settle();
		check("b oe", b_oe, 32'hF0);
		check("b out", b_out & 8'hF0, 32'hC0);
		check("c oe", c_oe, 32'hC);
		check("pu", {c_pu, b_pu}, 32'h30F);
		rd(lsp_pkg::OFF_PORT_B_DATA, 32'hCA, "b data");
		rd(lsp_pkg::OFF_PORT_C_DATA, 32'hB, "c data");
		b_ext_en <= 8'h00;
	endtask

	task automatic t_segments();
		logic [7:0] eb;
		logic [3:0] ec;
		seg_data <= 28'hA5C396E;
		com_data <= 4'h6;
		wr(lsp_pkg::OFF_PORT_B_MODE, 32'hFF);
		wr(lsp_pkg::OFF_PORT_C_MODE, 32'hF);
		settle();
		for (int i = 0; i < 8; i++)
			eb[i] = seg_data[27 - i];
		for (int i = 0; i < 4; i++)
			ec[i] = seg_data[19 - i];
		check("b seg", {b_oe, b_out}, {8'hFF, eb});
		check("c seg", {c_oe, c_out}, {4'hF, ec});
		check("ded", ded_seg, seg_data[15:0]);
		check("com", com_out, 32'h6);
		rd(lsp_pkg::OFF_PORT_B_DATA, 32'h0, "b ctrl data");
		rd(lsp_pkg::OFF_PORT_C_DATA, 32'h0, "c ctrl data");
	endtask

	task automatic t_unmapped();
		logic [31:0] r;
		logic        e;
		apb(1'b0, 8'h40, 32'h0, r, e);
		check("bad addr", {e, r[30:0]}, 32'h80000000);
	endtask

	task automatic t_pin_reset();
		int n;
		@(posedge clock);
		reset_pin_n <= 1'b0;
		n = 0;
		while (pin_reset_active !== 1'b1 && n < 10) begin
			@(posedge clock);
			n++;
		end
		check("pin rst", {31'h0, pin_reset_active}, 32'h1);
		if (pin_reset_active !== 1'b1) begin
			print_verdict();
		end else begin
			rd(lsp_pkg::OFF_STATUS, 32'h1, "status low");
			@(posedge clock);
			reset_pin_n <= 1'b1;
			settle();
			check("rst oe", {b_oe, c_oe}, 32'h0);
			check("pin rst off", {31'h0, pin_reset_active}, 32'h0);
			rd(lsp_pkg::OFF_STATUS, 32'h0, "status high");
			rd(lsp_pkg::OFF_PORT_B_MODE, 32'h0, "rst b mode");
		end
	endtask

	initial begin
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		t_reset_values();
		t_port_a();
		t_outputs();
		t_segments();
		t_unmapped();
		t_pin_reset();
		print_verdict();
	end
endmodule // testbench
